// ### src/bpg_defs.vh
// register offsets, field positions, reset values and ratios of the bridge pwm generator
`ifndef BPG_DEFS_VH
`define BPG_DEFS_VH

`define BPG_A_UNIT_CTL      4'h0
`define BPG_A_DUTY_HIGH     4'h1
`define BPG_A_PERIOD_LIMIT  4'h2
`define BPG_A_PERIOD_CTL    4'h3
`define BPG_A_WIDE_CTL      4'h4
`define BPG_A_CMP_LOW       4'h5
`define BPG_A_CMP_HIGH      4'h6
`define BPG_A_WIDE_LOW      4'h7
`define BPG_A_WIDE_HIGH     4'h8
`define BPG_A_INT_STATUS    4'h9
`define BPG_A_INT_MASK      4'hA
`define BPG_A_PIN_CMD       4'hB

`define BPG_RST_UNIT_CTL    8'h00
`define BPG_RST_DUTY_HIGH   8'h00
`define BPG_RST_PERIOD_LIM  8'hFF
`define BPG_RST_PERIOD_CTL  8'h00
`define BPG_RST_WIDE_CTL    8'h00
`define BPG_RST_CMP         8'h00
`define BPG_RST_INT_MASK    3'h0

`define BPG_MODE_PWM        2'h3
`define BPG_MODE_CMP_CLR    4'h9

`define BPG_BR_SINGLE       2'h0
`define BPG_BR_FULL_FWD     2'h1
`define BPG_BR_HALF         2'h2
`define BPG_BR_FULL_REV     2'h3

`define BPG_F_BRIDGE_HI     7
`define BPG_F_BRIDGE_LO     6
`define BPG_F_DLSB_HI       5
`define BPG_F_DLSB_LO       4
`define BPG_F_POL_AC        1
`define BPG_F_POL_BD        0
`define BPG_F_WPRE_HI       5
`define BPG_F_WPRE_LO       4
`define BPG_F_WIDE_ON       0
`define BPG_F_PT_ON         2

`define BPG_IRQ_PERIOD      0
`define BPG_IRQ_MATCH       1
`define BPG_IRQ_WRAP        2
`define BPG_IRQ_N           3

`define BPG_OSC_PER_COUNT   6'h04

`endif

// ### src/bpg_tick.v
// prescaled count tick: one pulse per four times two-to-the-shift clocks for shift 0 to 4, every 64 clocks above that
`timescale 1ns/10ps
module bpg_tick (
    input  wire       clk_sys, // system oscillator clock
    input  wire       reset,   // synchronous, active high
    input  wire       run,     // counting enabled
    input  wire [2:0] shift,   // log2 of prescale ratio
    output wire       tick,    // one-cycle count pulse
    output wire [5:0] phase    // clocks since last tick
);
`include "bpg_defs.vh"

    reg  [5:0] cnt_r;
    reg  [5:0] cnt_nxt;
    wire [5:0] lim;

    // four oscillator clocks per count, times the ratio
    assign lim   = (`BPG_OSC_PER_COUNT << shift) - 6'h01;
    assign tick  = run && (cnt_r == lim);
    assign phase = cnt_r;

    always @* begin
        cnt_nxt = cnt_r;
        if (!run) begin
            cnt_nxt = 6'h00;
        end else if (tick) begin
            cnt_nxt = 6'h00;
        end else begin
            cnt_nxt = cnt_r + 6'h01;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            cnt_r <= 6'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

// ### src/bpg_core.v
// bridge pwm generator: 10-bit pwm, bridge steering, 16-bit compare and interrupts
// Notes on behaviour
// RL1: the pwm waveform has a duty cycle set with 10-bit resolution.
// RL2: the pwm signal can be routed to bridge pins a, b or d by mode; pin c only ever carries a steady level.
// RL3: output modes are single on a, half-bridge on a and b, full forward and full reverse.
// RL4: in full-bridge the a/c pair and the b/d pair each choose active-high or active-low.
// RL5: pwm period is (period limit plus one) times four clocks times the period prescale.
// RL6: duty is the 8-bit duty byte above control bits 5:4, full scale 0x3FF.
// RL7: one control write selects pwm mode and sets both duty low bits together.
// RL8: in clear-on-match compare mode the pin goes low when the wide timer equals the compare.
// RL9: the wide timer prescale is 1:1, 1:2, 1:4 or 1:8 from its control bits 5:4.
// RL10: firmware sets the pin high while servicing the wide timer wrap interrupt, first.
// RL11: the wide timer counts per four clocks times prescale and wraps after 65536 counts.
// RL12: the firmware-assisted 16-bit pwm never reaches a full 100 percent duty.
// RL13: control bits 7:6 pick forward or reverse, all four pins driven in full-bridge.
// RL14: forward holds a active and modulates d; reverse holds c active and modulates b.
// RL15: output goes active at period restart and inactive when the count reaches duty.
// RL16: a new duty value takes effect only at the start of the next period.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
module bpg_core (
    input  wire       clk_sys,     // system oscillator clock
    input  wire       reset,       // synchronous, active high
    input  wire [3:0] reg_addr,    // register address
    input  wire [7:0] reg_wdata,   // write data
    input  wire       reg_wr,      // write strobe
    input  wire       reg_rd,      // read strobe
    output reg  [7:0] reg_rdata,   // read data, cycle after strobe
    output reg        bridge_out_a_o,  // pin a level
    output reg        bridge_out_a_oe, // pin a drive enable
    output reg        bridge_out_b_o,  // pin b level
    output reg        bridge_out_b_oe, // pin b drive enable
    output reg        bridge_out_c_o,  // pin c level
    output reg        bridge_out_c_oe, // pin c drive enable
    output reg        bridge_out_d_o,  // pin d level
    output reg        bridge_out_d_oe, // pin d drive enable
    output wire       irq              // level interrupt
);
`include "bpg_defs.vh"

    function is_pwm;
        input [7:0] ctl;
        begin
            is_pwm = (ctl[3:2] == `BPG_MODE_PWM);
        end
    endfunction

    function is_cmp_clr;
        input [7:0] ctl;
        begin
            is_cmp_clr = (ctl[3:0] == `BPG_MODE_CMP_CLR);
        end
    endfunction

    reg  [7:0]  unit_control_r;
    reg  [7:0]  duty_high_byte_r;
    reg  [7:0]  period_limit_r;
    reg  [7:0]  period_ctl_r;
    reg  [7:0]  wide_timer_control_r;
    reg  [7:0]  compare_low_byte_r;
    reg  [7:0]  compare_high_byte_r;
    reg  [`BPG_IRQ_N-1:0] int_status_r;
    reg  [`BPG_IRQ_N-1:0] int_mask_r;
    reg  [7:0]  period_timer_r;
    reg  [9:0]  duty_latch_r;
    reg  [15:0] wide_timer_r;
    reg         wide_upd_r;
    reg         cmp_pin_r;
    reg  [7:0]  rdata_nxt;
    reg  [3:0]  pin_o_nxt;
    reg  [3:0]  pin_oe_nxt;

    wire        wr_ctl;
    wire        pwm_on;
    wire        cmp_on;
    wire        wide_on;
    wire        pt_tick;
    wire [5:0]  pt_phase;
    wire [2:0]  pt_shift;
    wire        wt_tick;
    wire [2:0]  wt_shift;
    wire        period_end;
    wire [5:0]  pt_sub;
    wire [9:0]  ext_count;
    wire        pwm_raw;
    wire        pol_ac;
    wire        pol_bd;
    wire [15:0] cmp_val;
    wire        cmp_match;
    wire        wide_wrap;
    wire        clr_status;
    wire        pin_set_cmd;
    wire [`BPG_IRQ_N-1:0] evt;

    assign wr_ctl  = reg_wr && (reg_addr == `BPG_A_UNIT_CTL);
    assign pwm_on  = is_pwm(unit_control_r) && period_ctl_r[`BPG_F_PT_ON];
    assign cmp_on  = is_cmp_clr(unit_control_r);
    assign wide_on = wide_timer_control_r[`BPG_F_WIDE_ON];
    assign pol_ac  = unit_control_r[`BPG_F_POL_AC];
    assign pol_bd  = unit_control_r[`BPG_F_POL_BD];

    // period prescale 1, 4 or 16
    assign pt_shift = period_ctl_r[1] ? 3'h4 : (period_ctl_r[0] ? 3'h2 : 3'h0);

    // RL5 period timer tick
    bpg_tick u_period_tick (
        .clk_sys (clk_sys),
        .reset   (reset),
        .run     (pwm_on),
        .shift   (pt_shift),
        .tick    (pt_tick),
        .phase   (pt_phase)
    );

    // RL9 wide prescale select
    assign wt_shift = {1'b0, wide_timer_control_r[`BPG_F_WPRE_HI:`BPG_F_WPRE_LO]};

    // RL11 wide timer tick
    bpg_tick u_wide_tick (
        .clk_sys (clk_sys),
        .reset   (reset),
        .run     (wide_on),
        .shift   (wt_shift),
        .tick    (wt_tick),
        .phase   ()
    );

    // RL5 restart after limit count
    assign period_end = pt_tick && (period_timer_r == period_limit_r);

    // RL1 two sub-count bits below the timer
    assign pt_sub    = pt_phase >> pt_shift;
    assign ext_count = {period_timer_r, pt_sub[1:0]};

    // RL15 active from restart until count reaches duty
    assign pwm_raw = pwm_on && (ext_count < duty_latch_r);

    assign cmp_val   = {compare_high_byte_r, compare_low_byte_r};
    // RL8 equality seen once per timer step
    assign cmp_match = cmp_on && wide_upd_r && (wide_timer_r == cmp_val);
    assign wide_wrap = wt_tick && (wide_timer_r == 16'hFFFF);

    assign evt[`BPG_IRQ_PERIOD] = period_end;
    assign evt[`BPG_IRQ_MATCH]  = cmp_match;
    assign evt[`BPG_IRQ_WRAP]   = wide_wrap;

    assign clr_status  = reg_rd && (reg_addr == `BPG_A_INT_STATUS);
    // RL10 firmware raises pin from the wrap service
    assign pin_set_cmd = reg_wr && (reg_addr == `BPG_A_PIN_CMD) && reg_wdata[0];

    assign irq = |(int_status_r & int_mask_r);

    // register writes
    always @(posedge clk_sys) begin
        if (reset) begin
            unit_control_r       <= `BPG_RST_UNIT_CTL;
            duty_high_byte_r     <= `BPG_RST_DUTY_HIGH;
            period_limit_r       <= `BPG_RST_PERIOD_LIM;
            period_ctl_r         <= `BPG_RST_PERIOD_CTL;
            wide_timer_control_r <= `BPG_RST_WIDE_CTL;
            compare_low_byte_r   <= `BPG_RST_CMP;
            compare_high_byte_r  <= `BPG_RST_CMP;
            int_mask_r           <= `BPG_RST_INT_MASK;
        end else if (reg_wr) begin
            case (reg_addr)
                // RL7 mode and duty low bits in one write
                `BPG_A_UNIT_CTL: begin
                    unit_control_r <= reg_wdata;
                end
                `BPG_A_DUTY_HIGH: begin
                    duty_high_byte_r <= reg_wdata;
                end
                `BPG_A_PERIOD_LIMIT: begin
                    period_limit_r <= reg_wdata;
                end
                `BPG_A_PERIOD_CTL: begin
                    period_ctl_r <= reg_wdata;
                end
                `BPG_A_WIDE_CTL: begin
                    wide_timer_control_r <= reg_wdata;
                end
                `BPG_A_CMP_LOW: begin
                    compare_low_byte_r <= reg_wdata;
                end
                `BPG_A_CMP_HIGH: begin
                    compare_high_byte_r <= reg_wdata;
                end
                `BPG_A_INT_MASK: begin
                    int_mask_r <= reg_wdata[`BPG_IRQ_N-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // period timer and duty latch
    always @(posedge clk_sys) begin
        if (reset) begin
            period_timer_r <= 8'h00;
            duty_latch_r   <= 10'h000;
        end else if (!pwm_on) begin
            period_timer_r <= 8'h00;
            // RL6 duty byte above control bits 5:4
            duty_latch_r   <= {duty_high_byte_r,
                               unit_control_r[`BPG_F_DLSB_HI:`BPG_F_DLSB_LO]};
        end else if (period_end) begin
            period_timer_r <= 8'h00;
            // RL16 new duty only at period start
            duty_latch_r   <= {duty_high_byte_r,
                               unit_control_r[`BPG_F_DLSB_HI:`BPG_F_DLSB_LO]};
        end else if (pt_tick) begin
            period_timer_r <= period_timer_r + 8'h01;
        end
    end

    // wide timer, writable byte by byte
    always @(posedge clk_sys) begin
        if (reset) begin
            wide_timer_r <= 16'h0000;
            wide_upd_r   <= 1'b0;
        end else if (reg_wr && (reg_addr == `BPG_A_WIDE_LOW)) begin
            wide_timer_r <= {wide_timer_r[15:8], reg_wdata};
            wide_upd_r   <= 1'b0;
        end else if (reg_wr && (reg_addr == `BPG_A_WIDE_HIGH)) begin
            wide_timer_r <= {reg_wdata, wide_timer_r[7:0]};
            wide_upd_r   <= 1'b0;
        end else begin
            // RL11 wraps to zero after 65536 counts
            if (wt_tick) begin
                wide_timer_r <= wide_timer_r + 16'h0001;
            end
            wide_upd_r <= wt_tick;
        end
    end

    // compare-mode pin; firmware set wins over a same-cycle match
    always @(posedge clk_sys) begin
        if (reset) begin
            cmp_pin_r <= 1'b0;
        end else if (pin_set_cmd) begin
            cmp_pin_r <= 1'b1;
        end else if (cmp_match) begin
            // RL8 clear on match
            cmp_pin_r <= 1'b0;
        end
    end

    // sticky status, set wins over read clear
    genvar gi;
    generate
        for (gi = 0; gi < `BPG_IRQ_N; gi = gi + 1) begin : g_stat
            always @(posedge clk_sys) begin
                if (reset) begin
                    int_status_r[gi] <= 1'b0;
                end else if (evt[gi]) begin
                    int_status_r[gi] <= 1'b1;
                end else if (clr_status) begin
                    int_status_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // bridge steering
    always @* begin
        pin_o_nxt  = 4'h0;
        pin_oe_nxt = 4'h0;
        if (is_pwm(unit_control_r)) begin
            // RL2 route by output mode
            case (unit_control_r[`BPG_F_BRIDGE_HI:`BPG_F_BRIDGE_LO])
                // RL3 single output on a
                `BPG_BR_SINGLE: begin
                    pin_o_nxt[0]  = pwm_raw ^ pol_ac;
                    pin_oe_nxt[0] = 1'b1;
                end
                // RL3 half-bridge, b complements a
                `BPG_BR_HALF: begin
                    pin_o_nxt[0]  = pwm_raw ^ pol_ac;
                    pin_o_nxt[1]  = ~pwm_raw ^ pol_bd;
                    pin_oe_nxt[1:0] = 2'h3;
                end
                // RL14 forward: a active, d modulated
                `BPG_BR_FULL_FWD: begin
                    // RL4 pair polarity
                    pin_o_nxt[0] = ~pol_ac;
                    pin_o_nxt[1] = pol_bd;
                    pin_o_nxt[2] = pol_ac;
                    pin_o_nxt[3] = pwm_raw ^ pol_bd;
                    // RL13 all four driven
                    pin_oe_nxt   = 4'hF;
                end
                // RL14 reverse: c active, b modulated
                `BPG_BR_FULL_REV: begin
                    // RL4 pair polarity
                    pin_o_nxt[0] = pol_ac;
                    pin_o_nxt[1] = pwm_raw ^ pol_bd;
                    pin_o_nxt[2] = ~pol_ac;
                    pin_o_nxt[3] = pol_bd;
                    // RL13 all four driven
                    pin_oe_nxt   = 4'hF;
                end
                default: begin
                    pin_oe_nxt = 4'h0;
                end
            endcase
        end else if (cmp_on) begin
            // RL12 pin high only after firmware service
            pin_o_nxt[0]  = cmp_pin_r;
            pin_oe_nxt[0] = 1'b1;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            bridge_out_a_o  <= 1'b0;
            bridge_out_b_o  <= 1'b0;
            bridge_out_c_o  <= 1'b0;
            bridge_out_d_o  <= 1'b0;
            bridge_out_a_oe <= 1'b0;
            bridge_out_b_oe <= 1'b0;
            bridge_out_c_oe <= 1'b0;
            bridge_out_d_oe <= 1'b0;
        end else begin
            bridge_out_a_o  <= pin_o_nxt[0];
            bridge_out_b_o  <= pin_o_nxt[1];
            bridge_out_c_o  <= pin_o_nxt[2];
            bridge_out_d_o  <= pin_o_nxt[3];
            bridge_out_a_oe <= pin_oe_nxt[0];
            bridge_out_b_oe <= pin_oe_nxt[1];
            bridge_out_c_oe <= pin_oe_nxt[2];
            bridge_out_d_oe <= pin_oe_nxt[3];
        end
    end

    // read mux
    always @* begin
        case (reg_addr)
            `BPG_A_UNIT_CTL:     rdata_nxt = unit_control_r;
            `BPG_A_DUTY_HIGH:    rdata_nxt = duty_high_byte_r;
            `BPG_A_PERIOD_LIMIT: rdata_nxt = period_limit_r;
            `BPG_A_PERIOD_CTL:   rdata_nxt = period_ctl_r;
            `BPG_A_WIDE_CTL:     rdata_nxt = wide_timer_control_r;
            `BPG_A_CMP_LOW:      rdata_nxt = compare_low_byte_r;
            `BPG_A_CMP_HIGH:     rdata_nxt = compare_high_byte_r;
            `BPG_A_WIDE_LOW:     rdata_nxt = wide_timer_r[7:0];
            `BPG_A_WIDE_HIGH:    rdata_nxt = wide_timer_r[15:8];
            `BPG_A_INT_STATUS:   rdata_nxt = {5'h00, int_status_r};
            `BPG_A_INT_MASK:     rdata_nxt = {5'h00, int_mask_r};
            `BPG_A_PIN_CMD:      rdata_nxt = {bridge_out_d_o, bridge_out_c_o,
                                              bridge_out_b_o, bridge_out_a_o,
                                              3'h0, cmp_pin_r};
            default:             rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ### bench/bpg_core_monitor.sv
// port-level assertion checker for the bridge pwm generator
`timescale 1ns/10ps
module bpg_core_monitor (
    input wire logic       clk_sys,         // clock
    input wire logic       reset,           // sync reset
    input wire logic [3:0] reg_addr,        // address
    input wire logic [7:0] reg_wdata,       // write data
    input wire logic       reg_wr,          // write strobe
    input wire logic       reg_rd,          // read strobe
    input wire logic [7:0] reg_rdata,       // read data
    input wire logic       bridge_out_a_o,  // pin a
    input wire logic       bridge_out_a_oe, // pin a enable
    input wire logic       bridge_out_b_o,  // pin b
    input wire logic       bridge_out_b_oe, // pin b enable
    input wire logic       bridge_out_c_o,  // pin c
    input wire logic       bridge_out_c_oe, // pin c enable
    input wire logic       bridge_out_d_o,  // pin d
    input wire logic       bridge_out_d_oe, // pin d enable
    input wire logic       irq              // interrupt
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire [3:0] oe = {bridge_out_d_oe, bridge_out_c_oe, bridge_out_b_oe, bridge_out_a_oe};
    wire [3:0] lv = {bridge_out_d_o, bridge_out_c_o, bridge_out_b_o, bridge_out_a_o};
    sequence rd_of(logic [3:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence wr_full;
        reg_wr && (reg_addr < 4'h3 || reg_addr == 4'h5 || reg_addr == 4'h6);
    endsequence
    property readback_p;
        logic [3:0] a;
        logic [7:0] v;
        (wr_full, a = reg_addr, v = reg_wdata) ##1 (reg_rd && reg_addr == a) |=> reg_rdata == v;
    endproperty
    reset_quiet_a: assert property (disable iff (1'b0)
        reset |=> oe == 4'h0 && lv == 4'h0 && reg_rdata == 8'h00 && !irq)
        else $error("outputs active after reset");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without a read");
    unmapped_zero_a: assert property (reg_rd && reg_addr >= 4'hC |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    status_upper_a: assert property (rd_of(4'h9) |=> reg_rdata[7:3] == 5'h00)
        else $error("status upper bits set");
    mask_upper_a: assert property (rd_of(4'hA) |=> reg_rdata[7:3] == 5'h00)
        else $error("mask upper bits set");
    pincmd_upper_a: assert property (rd_of(4'hB) |=> reg_rdata[3:1] == 3'h0)
        else $error("pin register spare bits set");
    reg_readback_a: assert property (readback_p)
        else $error("register read back differs");
    bridge_pairs_a: assert property (oe == 4'hF |-> lv[0] != lv[2])
        else $error("bridge pair levels inconsistent");
    oe_legal_a: assert property (oe == 4'h0 || oe == 4'h1 || oe == 4'h3 || oe == 4'hF)
        else $error("illegal pin enable pattern");
    mask_off_a: assert property (reg_wr && reg_addr == 4'hA && reg_wdata[2:0] == 3'h0 |=> !irq)
        else $error("interrupt with mask cleared");
endmodule

bind bpg_core bpg_core_monitor u_mon (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bridge_out_a_o(bridge_out_a_o), .bridge_out_a_oe(bridge_out_a_oe), .bridge_out_b_o(bridge_out_b_o),
    .bridge_out_b_oe(bridge_out_b_oe), .bridge_out_c_o(bridge_out_c_o), .bridge_out_c_oe(bridge_out_c_oe),
    .bridge_out_d_o(bridge_out_d_o), .bridge_out_d_oe(bridge_out_d_oe), .irq(irq));

// ### bench/bpg_gate_model.sv
// gate driver inputs seen from the bridge pins
`timescale 1ns/10ps
module bpg_gate_model (
    input  wire logic [3:0] pin_o,   // pin levels d..a
    input  wire logic [3:0] pin_oe,  // pin enables d..a
    output wire logic [3:0] gate_in  // level at each driver
);
    assign gate_in = pin_o & pin_oe;
endmodule

// ### bench/tb_bpg_core.sv
// self-checking testbench for the bridge pwm generator
`timescale 1ns/10ps
module tb_bpg_core;
    logic       clk_sys   = 1'b0;
    logic       reset     = 1'b1;
    logic [3:0] reg_addr  = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic       prev      = 1'b0;
    wire  [7:0] reg_rdata;
    wire  [3:0] pin_o;
    wire  [3:0] pin_oe;
    wire  [3:0] lvl;
    wire        irq;
    int         errors    = 0;
    int         n_checks  = 0;
    int         run_cnt   = 0;
    int         hi_cnt    = 0;
    int         last_per  = 0;
    int         last_hi   = 0;
    int         m, p, k;
    logic [7:0] d;
    logic [3:0] eo, el;
    logic       f, ah, bh;

    always #2.5 clk_sys = ~clk_sys;

    bpg_core dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bridge_out_a_o(pin_o[0]), .bridge_out_a_oe(pin_oe[0]),
        .bridge_out_b_o(pin_o[1]), .bridge_out_b_oe(pin_oe[1]), .bridge_out_c_o(pin_o[2]),
        .bridge_out_c_oe(pin_oe[2]), .bridge_out_d_o(pin_o[3]), .bridge_out_d_oe(pin_oe[3]), .irq(irq));
    bpg_gate_model gates (.pin_o(pin_o), .pin_oe(pin_oe), .gate_in(lvl));

    // high time and period of pin a
    always @(posedge clk_sys) begin
        prev <= lvl[0];
        if (lvl[0] && !prev) begin
            last_per <= run_cnt;
            run_cnt <= 1;
            hi_cnt <= 1;
        end else begin
            run_cnt <= run_cnt + 1;
            if (lvl[0]) hi_cnt <= hi_cnt + 1;
        end
        if (!lvl[0] && prev) last_hi <= hi_cnt;
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // idle strobes, then let n edges pass
    task cyc(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask
    // strobe stays up; the next rd or cyc lowers it, a following wr keeps it up
    task wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
    endtask
    task rd(input logic [3:0] a, output logic [7:0] v);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        v = reg_rdata;
    endtask
    task wait_rise;
        int n;
        n = 0;
        @(posedge clk_sys);
        while (!(lvl[0] === 1'b1 && prev === 1'b0) && n < 600) begin
            @(posedge clk_sys);
            n++;
        end
        chk(n < 600, 1);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        tally_and_finish;
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (k = 0; k < 16; k++) begin
            rd(k[3:0], d);
            chk(d, (k == 2) ? 16'h00FF : 16'h0000);
        end
        wr(4'hD, 8'h5A);
        rd(4'hD, d);
        chk(d, 16'h0000);
        wr(4'h2, 8'h5A);
        rd(4'h2, d);
        chk(d, 16'h005A);
        $display("test registers done");
        wr(4'h2, 8'h03);
        wr(4'h1, 8'h01);
        wr(4'h0, 8'h3C);
        wr(4'h3, 8'h04);
        cyc(40);
        chk(last_per[15:0], 16);
        chk(last_hi[15:0], 7);
        wait_rise();
        wr(4'h0, 8'h0C);
        cyc(16);
        chk(last_hi[15:0], 7);
        cyc(16);
        chk(last_hi[15:0], 4);
        wr(4'h3, 8'h05);
        cyc(140);
        chk(last_per[15:0], 64);
        chk(last_hi[15:0], 16);
        wr(4'h3, 8'h04);
        $display("test pwm done");
        for (m = 0; m < 4; m++)
            for (p = 0; p < 4; p++)
                for (k = 0; k < 2; k++) begin
                    if ((m == 0 || m == 2) && p != 0) continue;
                    f = k[0];
                    ah = ~p[1];
                    bh = ~p[0];
                    wr(4'h1, f ? 8'hFF : 8'h00);
                    wr(4'h0, {m[1:0], f, f, 2'b11, p[1:0]});
                    cyc(36);
                    eo = (m == 0) ? 4'h1 : (m == 2) ? 4'h3 : 4'hF;
                    el = (m == 0) ? {3'b000, f} : (m == 2) ? {2'b00, ~f, f} :
                         (m == 1) ? {f ? bh : ~bh, ~ah, ~bh, ah} : {~bh, ah, f ? bh : ~bh, ~ah};
                    chk(pin_oe, eo);
                    chk(lvl, el);
                end
        $display("test bridge done");
        wr(4'h3, 8'h00);
        wr(4'h0, 8'h09);
        wr(4'h5, 8'h03);
        wr(4'h6, 8'h00);
        wr(4'h7, 8'hF0);
        wr(4'h8, 8'hFF);
        rd(4'h9, d);
        wr(4'hA, 8'h04);
        wr(4'h4, 8'h01);
        cyc(1);
        chk(irq, 0);
        k = 0;
        while (irq !== 1'b1 && k < 200) begin
            @(posedge clk_sys);
            k++;
        end
        chk(irq, 1);
        wr(4'hA, 8'h00);
        cyc(1);
        chk(irq, 0);
        wr(4'hA, 8'h04);
        cyc(1);
        chk(irq, 1);
        rd(4'h9, d);
        chk(d[2], 1);
        chk(irq, 0);
        wr(4'hB, 8'h01);
        cyc(2);
        chk(lvl[0], 1);
        rd(4'hB, d);
        chk({d[4], d[0]}, 2'b11);
        cyc(40);
        chk(lvl[0], 0);
        chk(last_hi < 14, 1);
        rd(4'h9, d);
        chk(d[1], 1);
        for (p = 0; p < 4; p++) begin
            wr(4'h4, 8'h00);
            wr(4'h7, 8'h00);
            wr(4'h8, 8'h00);
            wr(4'h4, {2'b00, p[1:0], 4'h1});
            cyc(32 << p);
            wr(4'h4, 8'h00);
            rd(4'h7, d);
            chk(d >= 8'h07 && d <= 8'h09, 1);
        end
        $display("test compare done");
        tally_and_finish;
    end
endmodule
